// ==== core/clkdiv_pkg.sv ====
// Constants and types shared by the output-pair divider block
// Operation
// - The low phase of a divider lasts its low-count nibble [7:4] plus one input cycles.
// - The high phase of a divider lasts its high-count nibble [3:0] plus one input cycles.
// - Bypass bit 7 powers the divider down and passes its input clock to its output.
// - The third pair's divider comes out of reset bypassed.
// - The second pair's divider comes out of reset in use.
// - Sync-ignore bit 6 clear obeys the chip sync request, set ignores it.
// - With forcing active the divider output is held at the force-level bit.
// - Start-polarity bit 4 sets the level the divider starts at after sync.
// - A four-bit phase offset delays the divider start by that many input cycles.
// - Direct-to-output clear drives the pair from its divider.
// - Direct-to-output set with source select 10b routes the oscillator to the pair.
// - Direct-to-output set with source select 00b routes the external clock to the pair.
// - With source select 01b direct-to-output has no effect.
// - The second pair's routing works the same way as the third pair's.
// - Duty-correction disable bit clear enables correction, set disables it.
package clkdiv_pkg;
   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_B_CNT  = 10'h193;
   localparam logic [9:0] IDX_B_CTL  = 10'h194;
   localparam logic [9:0] IDX_B_RTE  = 10'h195;
   localparam logic [9:0] IDX_C_CNT  = 10'h196;
   localparam logic [9:0] IDX_C_CTL  = 10'h197;
   localparam logic [9:0] IDX_C_RTE  = 10'h198;
   localparam logic [9:0] IDX_STATUS = 10'h1a0;
   // Control register fields
   localparam int CTL_BYPASS = 7;
   localparam int CTL_NOSYNC = 6;
   localparam int CTL_FORCE  = 5;
   localparam int CTL_START  = 4;
   localparam int PHASE_MSB  = 3;
   // Cycle count fields
   localparam int CNT_LO_LSB = 4;
   localparam int CNT_HI_MSB = 3;
   // Routing register fields
   localparam int RTE_DIRECT = 1;
   localparam int RTE_DUTY_CORRECT_DISABLE = 0;
   // Reset values
   localparam logic [7:0] RST_CNT   = 8'h00;
   localparam logic [7:0] RST_B_CTL = 8'h00;
   localparam logic [7:0] RST_C_CTL = 8'h80;
   localparam logic [7:0] RST_RTE   = 8'h00;
   // Distribution source select codes
   localparam logic [1:0] DIST_EXT    = 2'b00;
   localparam logic [1:0] DIST_VCODIV = 2'b01;
   localparam logic [1:0] DIST_OSC    = 2'b10;
   // Divider sequencing states
   typedef enum logic [1:0] {
      ST_HOLD  = 2'b00,
      ST_DELAY = 2'b01,
      ST_RUN   = 2'b10
   } div_state_t;
endpackage

// ==== core/channel_div.sv ====
// One output-pair divider: counts, phase delay, sync, force and bypass
`timescale 1ns/100ps
`default_nettype none
module channel_div
   import clkdiv_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       tick,
   input  wire logic       in_lvl,
   input  wire logic [7:0] cnt_reg,
   input  wire logic [7:0] ctl_reg,
   input  wire logic       sync_req,
   output logic            div_out,
   output logic            running
);
   typedef struct packed {
      div_state_t st;
      logic       lvl;
      logic [3:0] cnt;
      logic [3:0] ph;
   } div_t;

   div_t q;
   div_t d;
   logic [3:0] lo_cnt;
   logic [3:0] hi_cnt;
   logic       bypass;
   logic       nosync;

   // Field split
   assign lo_cnt = cnt_reg[7:CNT_LO_LSB];
   assign hi_cnt = cnt_reg[CNT_HI_MSB:0];
   assign bypass = ctl_reg[CTL_BYPASS];
   assign nosync = ctl_reg[CTL_NOSYNC];

   // Next state
   always_comb begin
      d = q;
      if (bypass) begin
         d.st  = ST_HOLD;
         d.lvl = in_lvl;
         d.cnt = 4'h0;
         d.ph  = 4'h0;
      end else if (sync_req && !nosync) begin
         d.st  = ST_HOLD;
         d.lvl = ctl_reg[CTL_START];
         d.cnt = 4'h0;
         d.ph  = ctl_reg[PHASE_MSB:0];
      end else if (sync_req) begin
         d.lvl = ctl_reg[CTL_FORCE];
      end else begin
         case (q.st)
            ST_HOLD: begin
               d.st = (q.ph == 4'h0) ? ST_RUN : ST_DELAY;
            end
            ST_DELAY: begin
               if (tick) begin
                  d.ph = q.ph - 4'h1;
                  if (q.ph == 4'h1) begin
                     d.st = ST_RUN;
                  end
               end
            end
            ST_RUN: begin
               if (tick) begin
                  // Half period ends at field value, ratio is sum of both plus two
                  if (q.cnt == (q.lvl ? hi_cnt : lo_cnt)) begin
                     d.lvl = ~q.lvl;
                     d.cnt = 4'h0;
                  end else begin
                     d.cnt = q.cnt + 4'h1;
                  end
               end
            end
            default: begin
               d.st = ST_HOLD;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '{st: ST_HOLD, lvl: 1'b0, cnt: 4'h0, ph: 4'h0};
      end else begin
         q <= d;
      end
   end

   assign div_out = q.lvl;
   assign running = (q.st == ST_RUN);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_sync_hold;
      sync_req && !nosync && !bypass;
   endsequence
   sequence s_release;
      s_sync_hold ##1 (!sync_req && !bypass && ctl_reg[PHASE_MSB:0] != 4'h0);
   endsequence

   AST_BYPASS_PASS: assert property (bypass |=> div_out == $past(in_lvl))
      else $error("bypassed divider did not pass its input");
   AST_LOW_END: assert property (!bypass && !sync_req && running && tick && !q.lvl
      && q.cnt == lo_cnt |=> div_out)
      else $error("low phase did not end at low count");
   AST_LOW_STAY: assert property (!bypass && !sync_req && running && !q.lvl
      && q.cnt < lo_cnt |=> !div_out)
      else $error("low phase ended early");
   AST_HIGH_END: assert property (!bypass && !sync_req && running && tick && q.lvl
      && q.cnt == hi_cnt |=> !div_out)
      else $error("high phase did not end at high count");
   AST_SYNC_START: assert property (s_sync_hold |=> div_out == $past(ctl_reg[CTL_START])
      && !running)
      else $error("sync did not hold start level");
   AST_FORCE_LVL: assert property (sync_req && nosync && !bypass
      |=> div_out == $past(ctl_reg[CTL_FORCE]))
      else $error("forced level not held");
   AST_PHASE_WAIT: assert property (s_release |-> !running ##1 !running)
      else $error("divider ran before phase offset elapsed");
endmodule
`default_nettype wire

// ==== core/lvpecl_channel_divider.sv ====
// Second and third output-pair dividers with APB register access
//
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none
module lvpecl_channel_divider
   import clkdiv_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        div_tick,
   input  wire logic        div_lvl,
   input  wire logic        osc_lvl,
   input  wire logic        ext_lvl,
   input  wire logic [1:0]  dist_sel,
   input  wire logic        sync_req,
   output logic             pair_b_out_a,
   output logic             pair_b_out_b,
   output logic             pair_c_out_a,
   output logic             pair_c_out_b,
   output logic             b_powered_down,
   output logic             c_powered_down,
   output logic             b_duty_correct_disable,
   output logic             c_duty_correct_disable
);
   // All block state in one record
   typedef struct packed {
      logic [7:0]  b_cnt;
      logic [7:0]  b_ctl;
      logic [7:0]  b_rte;
      logic [7:0]  c_cnt;
      logic [7:0]  c_ctl;
      logic [7:0]  c_rte;
      logic [31:0] rdata;
      logic        pair_b;
      logic        pair_c;
   } top_t;

   top_t q;
   top_t d;

   logic [9:0]  idx;
   logic        hit;
   logic [31:0] rd_mux;
   logic        wr_en;
   logic        b_div;
   logic        c_div;
   logic        b_run;
   logic        c_run;

   // Word index of the access
   assign idx = paddr[11:2];

   // Address decode and read data selection
   always_comb begin
      hit    = 1'b1;
      rd_mux = 32'h0000_0000;
      case (idx)
         IDX_B_CNT: begin
            rd_mux = {24'h00_0000, q.b_cnt};
         end
         IDX_B_CTL: begin
            rd_mux = {24'h00_0000, q.b_ctl};
         end
         IDX_B_RTE: begin
            rd_mux = {30'h0000_0000, q.b_rte[1:0]};
         end
         IDX_C_CNT: begin
            rd_mux = {24'h00_0000, q.c_cnt};
         end
         IDX_C_CTL: begin
            rd_mux = {24'h00_0000, q.c_ctl};
         end
         IDX_C_RTE: begin
            rd_mux = {30'h0000_0000, q.c_rte[1:0]};
         end
         IDX_STATUS: begin
            rd_mux = {27'h000_0000, sync_req, c_run, b_run, c_div, b_div};
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // Zero-wait slave; unmapped addresses answer with an error
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign wr_en   = psel && penable && pwrite && hit;
   assign prdata  = q.rdata;

   // Divider for the second pair
   channel_div u_div_b (
      .pclk     (pclk),
      .presetn  (presetn),
      .tick     (div_tick),
      .in_lvl   (div_lvl),
      .cnt_reg  (q.b_cnt),
      .ctl_reg  (q.b_ctl),
      .sync_req (sync_req),
      .div_out  (b_div),
      .running  (b_run)
   );

   // Divider for the third pair
   channel_div u_div_c (
      .pclk     (pclk),
      .presetn  (presetn),
      .tick     (div_tick),
      .in_lvl   (div_lvl),
      .cnt_reg  (q.c_cnt),
      .ctl_reg  (q.c_ctl),
      .sync_req (sync_req),
      .div_out  (c_div),
      .running  (c_run)
   );

   // Select what drives an output pair
   function automatic logic route_sel(
      input logic       direct,
      input logic [1:0] src,
      input logic       div_o,
      input logic       osc_i,
      input logic       ext_i
   );
      logic r;
      r = div_o;
      if (direct) begin
         case (src)
            DIST_OSC: begin
               r = osc_i;
            end
            DIST_EXT: begin
               r = ext_i;
            end
            default: begin
               r = div_o;
            end
         endcase
      end
      return r;
   endfunction

   // Register writes, read capture and output routing
   always_comb begin
      d = q;
      if (psel && !penable) begin
         d.rdata = pwrite ? 32'h0000_0000 : rd_mux;
      end
      if (wr_en) begin
         case (idx)
            IDX_B_CNT: begin
               d.b_cnt = pwdata[7:0];
            end
            IDX_B_CTL: begin
               d.b_ctl = pwdata[7:0];
            end
            IDX_B_RTE: begin
               d.b_rte = {6'h00, pwdata[1:0]};
            end
            IDX_C_CNT: begin
               d.c_cnt = pwdata[7:0];
            end
            IDX_C_CTL: begin
               d.c_ctl = pwdata[7:0];
            end
            IDX_C_RTE: begin
               d.c_rte = {6'h00, pwdata[1:0]};
            end
            default: begin
               d.rdata = q.rdata;
            end
         endcase
      end
      d.pair_b = route_sel(q.b_rte[RTE_DIRECT], dist_sel, b_div,
                           osc_lvl, ext_lvl);
      d.pair_c = route_sel(q.c_rte[RTE_DIRECT], dist_sel, c_div,
                           osc_lvl, ext_lvl);
   end

   // State register with documented defaults
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q.b_cnt  <= RST_CNT;
         q.b_ctl  <= RST_B_CTL;
         q.b_rte  <= RST_RTE;
         q.c_cnt  <= RST_CNT;
         q.c_ctl  <= RST_C_CTL;
         q.c_rte  <= RST_RTE;
         q.rdata  <= 32'h0000_0000;
         q.pair_b <= 1'b0;
         q.pair_c <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // Both legs of a pair carry the same clock
   assign pair_b_out_a = q.pair_b;
   assign pair_b_out_b = q.pair_b;
   assign pair_c_out_a = q.pair_c;
   assign pair_c_out_b = q.pair_c;

   // Analog controls steered by the registers
   assign b_powered_down         = q.b_ctl[CTL_BYPASS];
   assign c_powered_down         = q.c_ctl[CTL_BYPASS];
   assign b_duty_correct_disable = q.b_rte[RTE_DUTY_CORRECT_DISABLE];
   assign c_duty_correct_disable = q.c_rte[RTE_DUTY_CORRECT_DISABLE];

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_write_c_ctl;
      psel && penable && pwrite && idx == IDX_C_CTL;
   endsequence
   sequence s_write_b_ctl;
      psel && penable && pwrite && idx == IDX_B_CTL;
   endsequence

   AST_C_RESET_BYPASS: assert property ($rose(presetn) |-> q.c_ctl[CTL_BYPASS]
      && c_powered_down)
      else $error("third divider not bypassed after reset");
   AST_B_RESET_USED: assert property ($rose(presetn) |-> !q.b_ctl[CTL_BYPASS]
      && !b_powered_down)
      else $error("second divider bypassed after reset");
   AST_CTL_WRITE: assert property (s_write_c_ctl |=> q.c_ctl == $past(pwdata[7:0]))
      else $error("control write lost");
   AST_B_CTL_WRITE: assert property (s_write_b_ctl |=> b_powered_down
      == $past(pwdata[CTL_BYPASS]))
      else $error("bypass write did not reach power-down");
   AST_OSC_ROUTE: assert property (q.c_rte[RTE_DIRECT] && dist_sel == DIST_OSC
      |=> pair_c_out_a == $past(osc_lvl))
      else $error("oscillator not routed to pair");
   AST_EXT_ROUTE: assert property (q.b_rte[RTE_DIRECT] && dist_sel == DIST_EXT
      |=> pair_b_out_b == $past(ext_lvl))
      else $error("external clock not routed to pair");
   AST_NO_EFFECT: assert property (q.c_rte[RTE_DIRECT] && dist_sel == DIST_VCODIV
      |=> pair_c_out_b == $past(c_div))
      else $error("direct bit acted with source 01b");
   AST_DIV_ROUTE: assert property (!q.b_rte[RTE_DIRECT] |=> pair_b_out_a == $past(b_div))
      else $error("pair not driven by divider");
   AST_DCC_FOLLOW: assert property (psel && penable && pwrite && idx == IDX_C_RTE
      |=> c_duty_correct_disable == $past(pwdata[RTE_DUTY_CORRECT_DISABLE]))
      else $error("duty correction control not updated");
   AST_SLVERR: assert property (psel && penable && !hit |-> pslverr && pready)
      else $error("unmapped access not refused");
endmodule
`default_nettype wire

// ==== sim/pair_receiver.sv ====
// Downstream receiver model: measures high and low run lengths of one output pair
`timescale 1ns/100ps
`default_nettype none
module pair_receiver (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic leg_a,
   input  wire logic leg_b,
   output var  int   high_len,
   output var  int   low_len,
   output logic      legs_apart
);
   logic prev_q;
   int   run_q;
   // Length of the last finished run of each level, in clock cycles
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q     <= 1'b0;
         run_q      <= 1;
         high_len   <= 0;
         low_len    <= 0;
         legs_apart <= 1'b0;
      end else begin
         prev_q <= leg_a;
         if (leg_a !== prev_q) begin
            run_q <= 1;
            if (prev_q) high_len <= run_q;
            else low_len <= run_q;
         end else begin
            run_q <= run_q + 1;
         end
         legs_apart <= legs_apart | (leg_a !== leg_b); // Both legs carry one clock
      end
   end
endmodule
`default_nettype wire

// ==== sim/lvpecl_channel_divider_test.sv ====
// Self-checking bench for the output-pair divider block
`timescale 1ns/100ps
`default_nettype none
module lvpecl_channel_divider_test;
   import clkdiv_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err_q, div_tick = 0, div_lvl = 0, osc_lvl = 0, ext_lvl = 0;
   logic [1:0] dist_sel = 2'b01;
   logic sync_req = 0, b_a, b_b, c_a, c_b, b_pd, c_pd, b_dcc, c_dcc, b_apart, c_apart;
   int num_errors = 0, check_count = 0, cycles = 0, b_hi, b_lo, c_hi, c_lo, t0, t4;
   always #2 pclk = ~pclk;
   // Divider input clock at half the bus clock, tick on its rising edge
   always @(posedge pclk) begin
      div_lvl  <= ~div_lvl;
      div_tick <= ~div_lvl;
   end
   lvpecl_channel_divider u_lvpecl_channel_divider (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .div_tick(div_tick),
      .div_lvl(div_lvl), .osc_lvl(osc_lvl), .ext_lvl(ext_lvl), .dist_sel(dist_sel),
      .sync_req(sync_req), .pair_b_out_a(b_a), .pair_b_out_b(b_b), .pair_c_out_a(c_a),
      .pair_c_out_b(c_b), .b_powered_down(b_pd), .c_powered_down(c_pd),
      .b_duty_correct_disable(b_dcc), .c_duty_correct_disable(c_dcc));
   pair_receiver u_rx_b (.clk(pclk), .rst_n(presetn), .leg_a(b_a), .leg_b(b_b),
      .high_len(b_hi), .low_len(b_lo), .legs_apart(b_apart));
   pair_receiver u_rx_c (.clk(pclk), .rst_n(presetn), .leg_a(c_a), .leg_b(c_b),
      .high_len(c_hi), .low_len(c_lo), .legs_apart(c_apart));
   // Compare one value and count it
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One APB transfer; read data and error taken at the pready edge
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      // This wait ends at the first edge with pready high
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // Register defaults and an unmapped place
   task automatic t_reset;
      apb(0, IDX_B_CTL, 8'h00); check("b ctl", 32'h00, rd);
      apb(0, IDX_C_CTL, 8'h00); check("c ctl", 32'h80, rd);
      apb(0, IDX_C_CNT, 8'h00); check("c cnt", 32'h00, rd);
      apb(0, IDX_C_RTE, 8'h00); check("c rte", 32'h00, rd);
      check("pd", 2'b10, {c_pd, b_pd});
      apb(1, 10'h1ff, 8'h5a); check("unmapped err", 1, err_q);
      apb(0, 10'h1ff, 8'h00); check("unmapped rd", 0, rd);
   endtask
   // Divide ratios: pair b divides, pair c bypassed follows its input
   task automatic t_ratio;
      apb(1, IDX_B_CNT, 8'h21); apb(0, IDX_B_CNT, 8'h00); check("b cnt", 32'h21, rd);
      wait_cyc(40);
      check("b low", 6, b_lo);
      check("b high", 4, b_hi);
      check("c high", 1, c_hi);
      check("c low", 1, c_lo);
      apb(1, IDX_C_CTL, 8'h00); apb(1, IDX_C_CNT, 8'h03); wait_cyc(40);
      check("c pd off", 0, c_pd);
      check("c ratio", 10, c_hi + c_lo);
   endtask
   // Direct routing on both pairs for source codes 00b and 10b, on pair b for 01b, and duty control
   task automatic t_route;
      logic [1:0] s;
      apb(1, IDX_B_RTE, 8'h03); apb(1, IDX_C_RTE, 8'h03); wait_cyc(1);
      check("b dcc", 1, b_dcc);
      check("c dcc", 1, c_dcc);
      for (int i = 0; i < 3; i++) begin
         s = i[1:0];
         dist_sel <= s; osc_lvl <= 1'b1; ext_lvl <= 1'b0; wait_cyc(3);
         if (s == DIST_OSC) check("osc b", 1, b_a);
         if (s == DIST_EXT) check("ext c", 0, c_a);
         osc_lvl <= 1'b0; ext_lvl <= 1'b1; wait_cyc(3);
         if (s == DIST_OSC) check("osc c", 0, c_a);
         if (s == DIST_EXT) check("ext b", 1, b_a);
      end
      // Source 01b with the direct bit still set keeps the divider
      dist_sel <= DIST_VCODIV; wait_cyc(40);
      check("src01 b", 10, b_hi + b_lo);
      // Direct bit clear ignores an oscillator source
      dist_sel <= DIST_OSC; apb(1, IDX_B_RTE, 8'h00); wait_cyc(40);
      check("divider b", 10, b_hi + b_lo);
      check("b dcc off", 0, b_dcc);
   endtask
   // Sync hold at start level, forcing, and phase delay
   task automatic t_sync;
      int n;
      apb(1, IDX_B_CNT, 8'h00);
      for (int p = 0; p < 8; p += 4) begin
         apb(1, IDX_B_CTL, 8'h10); sync_req <= 1'b1; wait_cyc(6);
         check("start hi", 1, b_a);
         apb(1, IDX_B_CTL, p[7:0]); wait_cyc(6);
         check("start lo", 0, b_a);
         do @(posedge pclk); while (div_tick !== 1'b1);
         sync_req <= 1'b0;
         n = 0;
         do begin @(posedge pclk); n++; end while (b_a !== 1'b1 && n < 100);
         if (p == 0) t0 = n; else t4 = n;
      end
      check("phase", 8, t4 - t0);
      apb(1, IDX_B_CTL, 8'h60); sync_req <= 1'b1; wait_cyc(6);
      check("force hi", 1, b_a);
      // Pair b ignores sync and keeps running, pair c is held low
      apb(0, IDX_STATUS, 8'h00); check("status", 32'h15, rd);
      apb(1, IDX_B_CTL, 8'h40); wait_cyc(6);
      check("force lo", 0, b_a);
      sync_req <= 1'b0;
      check("legs", 0, {b_apart, c_apart});
   endtask
   task automatic test_done;
      $display("Checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Hang guard
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         test_done();
      end
   end
   initial begin
      wait_cyc(10);
      presetn <= 1'b1;
      t_reset();
      t_ratio();
      t_route();
      t_sync();
      test_done();
   end
endmodule
`default_nettype wire
